/* File: hw/sddma_pkg.sv */
// Package: register map, fields, reset values and carriers for the sound DMA channel
package sddma_pkg;
  localparam logic [11:0] SDDMA_OFF_CUR_A = 12'h180;
  localparam logic [11:0] SDDMA_OFF_END_A = 12'h184;
  localparam logic [11:0] SDDMA_OFF_CUR_B = 12'h188;
  localparam logic [11:0] SDDMA_OFF_END_B = 12'h18C;
  localparam logic [11:0] SDDMA_OFF_CTRL = 12'h190;
  localparam logic [11:0] SDDMA_OFF_STATE = 12'h194;
  localparam int SDDMA_ADDR_W = 12;
  localparam int SDDMA_PTR_HI = 28;
  localparam int SDDMA_PAGE_LO = 12;
  localparam int SDDMA_OFS_HI = 11;
  localparam int SDDMA_OFS_LO = 4;
  localparam int SDDMA_STOP_BIT = 31;
  localparam int SDDMA_LAST_BIT = 30;
  localparam int SDDMA_CLR_BIT = 7;
  localparam int SDDMA_EN_BIT = 5;
  localparam logic [4:0] SDDMA_CTRL_CONST = 5'h10;
  localparam logic [24:0] SDDMA_QUAD_STEP = 25'h0000001;
  localparam logic [2:0] SDDMA_STATE_RESET = 3'h6;
  localparam int SDDMA_FIFO_DEPTH = 4;
  localparam int SDDMA_QUAD_W = 128;
  localparam logic [1:0] SDDMA_RESP_OKAY = 2'h0;
  localparam logic [1:0] SDDMA_RESP_SLVERR = 2'h2;

  // Buffer pair: pointer in quad-word units plus end fields
  typedef struct packed {
    logic [24:0] ptr;
    logic [7:0] end_ofs;
    logic stop;
    logic last;
    logic fresh;
  } sddma_pair_type;

  typedef struct packed {
    logic overrun;
    logic irq;
    logic buf_b;
  } sddma_state_type;

  typedef enum logic [1:0] {
    SDDMA_IDLE = 2'b00,
    SDDMA_REQ = 2'b01,
    SDDMA_WAIT = 2'b10,
    SDDMA_HALT = 2'b11
  } sddma_fsm_type;
endpackage

/* File: hw/sddma_fifo.sv */
// Holds no logic: the output FIFO module sits with the channel logic in sddma_top.sv

/* File: hw/sddma_top.sv */
// Sound DMA double-buffer channel: AXI4-Lite registers, fetch engine, output FIFO
// Operation
// R01: Current-pointer write takes page from bits 28:12, offset from 11:4.
// R02: Each completed fetch advances the active pointer by sixteen bytes.
// R03: Current-pointer read gives location in 28:4, zeros below.
// R04: End register holds final quad-word offset in bits 11:4.
// R05: Stop bit set halts channel at buffer end; clear keeps going.
// R06: Last bit set marks the final quad-word transfer of the buffer.
// R07: Software keeps last clear except for single-transfer initialisation.
// R08: End register read returns bits 31, 30, 11:4 written, zeros below.
// R09: Pair B behaves like pair A, enabling double buffering.
// R10: Control bit 7 write forces overrun with interrupt; self-clears, reads zero.
// R11: Control bit 5 enables channel, reads back, resets to zero.
// R12: Control reads bit 6 zero and bits 4:0 as 10000.
// R13: Only clear and enable bits of control are writable.
// R14: Read-only three-bit state: overrun, interrupt, active buffer; resets 110.
// R15: At end without stop, switch pairs, raise interrupt, flag overrun if stale.
// R16: Fetch only while enabled; pass quad words on in fetch order.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module sddma_top
  import sddma_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [SDDMA_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [SDDMA_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory read request
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic [28:0] mem_req_addr,
  // Memory read data
  input wire logic mem_rsp_valid,
  input wire logic [SDDMA_QUAD_W-1:0] mem_rsp_data,
  // Sound output stream
  output logic snd_valid,
  input wire logic snd_ready,
  output logic [SDDMA_QUAD_W-1:0] snd_data,
  // Channel status
  output logic snd_irq,
  output logic snd_last
);
  // Write channel capture
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [SDDMA_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic wr_fire;
  logic wr_hit;

  // Channel state
  sddma_pair_type pair_a, pair_b, next_pair_a, next_pair_b;
  sddma_state_type st, next_st;
  logic enable, next_enable;
  sddma_fsm_type fsm, next_fsm;
  logic last_out, next_last_out;
  logic fifo_in_ready;
  logic [28:0] req_addr, next_req_addr;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign wr_fire = aw_held && w_held && !bvalid;

  function automatic logic [31:0] cur_word(input sddma_pair_type p);
    // R03 location read back
    cur_word = {3'b000, p.ptr, 4'h0};
  endfunction

  function automatic logic [31:0] end_word(input sddma_pair_type p);
    // R08 end read back
    end_word = {p.stop, p.last, 18'h00000, p.end_ofs, 4'h0};
  endfunction

  // Register write path
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    wr_hit = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      wr_hit = (aw_addr[SDDMA_ADDR_W-1:2] >= SDDMA_OFF_CUR_A[SDDMA_ADDR_W-1:2])
        && (aw_addr[SDDMA_ADDR_W-1:2] <= SDDMA_OFF_STATE[SDDMA_ADDR_W-1:2]);
      next_bresp = wr_hit ? SDDMA_RESP_OKAY : SDDMA_RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Register read path
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = SDDMA_RESP_OKAY;
      case ({s_axi_araddr[SDDMA_ADDR_W-1:2], 2'b00})
        SDDMA_OFF_CUR_A: next_rdata = cur_word(pair_a);
        SDDMA_OFF_END_A: next_rdata = end_word(pair_a);
        SDDMA_OFF_CUR_B: next_rdata = cur_word(pair_b);
        SDDMA_OFF_END_B: next_rdata = end_word(pair_b);
        // R12 fixed pattern and zero bits
        SDDMA_OFF_CTRL: next_rdata = {24'h000000, 2'b00, enable, SDDMA_CTRL_CONST};
        // R14 state read-only
        SDDMA_OFF_STATE: next_rdata = {29'h00000000, st};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = SDDMA_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Fetch engine and register updates
  always_comb begin
    sddma_pair_type act;
    logic at_end;
    logic fetch_done;
    logic raise;
    act = st.buf_b ? pair_b : pair_a;
    at_end = (act.ptr[7:0] == act.end_ofs);
    fetch_done = mem_rsp_valid && (fsm == SDDMA_WAIT);
    raise = 1'b0;
    next_pair_a = pair_a;
    next_pair_b = pair_b;
    next_st = st;
    next_enable = enable;
    next_fsm = fsm;
    next_last_out = last_out;
    next_req_addr = req_addr;
    case (fsm)
      // R16 fetch only while enabled
      SDDMA_IDLE: if (enable && fifo_in_ready) begin
        next_fsm = SDDMA_REQ;
        // Address latched so the request stands unchanged
        next_req_addr = {act.ptr, 4'h0};
      end
      SDDMA_REQ: if (mem_req_ready) next_fsm = SDDMA_WAIT;
      SDDMA_WAIT: if (mem_rsp_valid) next_fsm = SDDMA_IDLE;
      SDDMA_HALT: if (!enable) next_fsm = SDDMA_IDLE;
      default: next_fsm = SDDMA_IDLE;
    endcase
    // Completed fetch: end test, switch, advance
    if (fetch_done) begin
      next_last_out = act.last;
      // R06 last transfer ends the buffer at once
      if (at_end || act.last) begin
        // R05 stop at end
        if (act.stop || act.last) begin
          next_fsm = SDDMA_HALT;
        end else begin
          // R15 switch and interrupt
          raise = 1'b1;
          next_st.buf_b = !st.buf_b;
          next_st.irq = 1'b1;
          next_st.overrun = st.overrun || (st.buf_b ? !pair_a.fresh : !pair_b.fresh);
        end
        if (st.buf_b) next_pair_b.fresh = 1'b0;
        else next_pair_a.fresh = 1'b0;
      end
      // R02 advance by one quad word
      if (st.buf_b) next_pair_b.ptr = pair_b.ptr + SDDMA_QUAD_STEP;
      else next_pair_a.ptr = pair_a.ptr + SDDMA_QUAD_STEP;
    end
    if (wr_fire) begin
      // R09 both pairs share one write form
      case ({aw_addr[SDDMA_ADDR_W-1:2], 2'b00})
        SDDMA_OFF_CUR_A: if (w_strb == 4'hF) begin
          // R01 page and offset
          next_pair_a.ptr = w_data[SDDMA_PTR_HI:SDDMA_OFS_LO];
          next_pair_a.fresh = 1'b1;
          // R15 reprogramming acknowledges; new interrupt wins
          if (!raise) begin
            next_st.irq = 1'b0;
            next_st.overrun = 1'b0;
          end
        end
        SDDMA_OFF_CUR_B: if (w_strb == 4'hF) begin
          // R09 same as pair A
          next_pair_b.ptr = w_data[SDDMA_PTR_HI:SDDMA_OFS_LO];
          next_pair_b.fresh = 1'b1;
          if (!raise) begin
            next_st.irq = 1'b0;
            next_st.overrun = 1'b0;
          end
        end
        SDDMA_OFF_END_A: if (w_strb == 4'hF) begin
          // R04 end offset stored
          next_pair_a.end_ofs = w_data[SDDMA_OFS_HI:SDDMA_OFS_LO];
          next_pair_a.stop = w_data[SDDMA_STOP_BIT];
          next_pair_a.last = w_data[SDDMA_LAST_BIT];
        end
        SDDMA_OFF_END_B: if (w_strb == 4'hF) begin
          next_pair_b.end_ofs = w_data[SDDMA_OFS_HI:SDDMA_OFS_LO];
          next_pair_b.stop = w_data[SDDMA_STOP_BIT];
          next_pair_b.last = w_data[SDDMA_LAST_BIT];
        end
        SDDMA_OFF_CTRL: if (w_strb[0]) begin
          // R13 only enable stored
          // R11 enable bit
          next_enable = w_data[SDDMA_EN_BIT];
          // R10 clear forces overrun and interrupt
          if (w_data[SDDMA_CLR_BIT]) begin
            next_st.overrun = 1'b1;
            next_st.irq = 1'b1;
          end
        end
        default: next_enable = enable;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= SDDMA_RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= SDDMA_RESP_OKAY;
      pair_a <= '0;
      pair_b <= '0;
      // R14 reset state 110
      st <= SDDMA_STATE_RESET;
      enable <= 1'b0;
      fsm <= SDDMA_IDLE;
      last_out <= 1'b0;
      req_addr <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      pair_a <= next_pair_a;
      pair_b <= next_pair_b;
      st <= next_st;
      enable <= next_enable;
      fsm <= next_fsm;
      last_out <= next_last_out;
      req_addr <= next_req_addr;
    end
  end

  assign mem_req_valid = (fsm == SDDMA_REQ);
  assign mem_req_addr = req_addr;
  assign snd_irq = st.irq;
  assign snd_last = last_out;

  // R16 fetched quad words kept in order
  sddma_fifo #(
    .WIDTH(SDDMA_QUAD_W),
    .DEPTH(SDDMA_FIFO_DEPTH)
  ) sddma_fifo_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(mem_rsp_valid && (fsm == SDDMA_WAIT)),
    .in_ready(fifo_in_ready),
    .in_data(mem_rsp_data),
    .out_valid(snd_valid),
    .out_ready(snd_ready),
    .out_data(snd_data)
  );
endmodule

// Output FIFO: fetched quad words leave in arrival order
module sddma_fifo #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at the last entry
  always_comb begin
    next_wptr = push ? ((wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1) : wptr;
    next_rptr = pop ? ((rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1) : rptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end
endmodule

/* File: verif/sddma_props.sv */
// Checker: port-level properties of the sound DMA channel
`timescale 1ns/1ns
module sddma_props
  import sddma_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register reads
  input wire logic [SDDMA_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // Register write answer
  input wire logic s_axi_bvalid,
  // Memory and stream
  input wire logic mem_req_valid,
  input wire logic mem_req_ready,
  input wire logic [28:0] mem_req_addr,
  input wire logic snd_valid,
  input wire logic snd_ready,
  input wire logic [SDDMA_QUAD_W-1:0] snd_data,
  input wire logic snd_irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic ar_go;
  assign ar_go = s_axi_arvalid && s_axi_arready;
  AST_RESET_STATE: assert property ($rose(aresetn) |-> snd_irq && !mem_req_valid && !snd_valid)
    else $error("state after reset wrong");
  AST_IRQ_ACK: assert property ($fell(snd_irq) |-> $rose(s_axi_bvalid))
    else $error("interrupt dropped without a register write");
  AST_REQ_HOLD: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req_addr))
    else $error("fetch request not held");
  AST_ONE_OUT: assert property (mem_req_valid && mem_req_ready |=> !mem_req_valid)
    else $error("second fetch while one outstanding");
  AST_ADDR_ALIGN: assert property (mem_req_valid |-> mem_req_addr[3:0] == 4'h0)
    else $error("fetch address not quad aligned");
  AST_SND_HOLD: assert property (snd_valid && !snd_ready |=> snd_valid && $stable(snd_data))
    else $error("sound word not held");
  AST_CTRL_READ: assert property (ar_go && s_axi_araddr == SDDMA_OFF_CTRL |=> s_axi_rdata[7:6] == 2'h0 && s_axi_rdata[4:0] == 5'h10)
    else $error("control read pattern wrong");
  AST_PTR_READ: assert property (ar_go && s_axi_araddr <= SDDMA_OFF_END_B |-> ##1 s_axi_rvalid && s_axi_rdata[3:0] == 4'h0)
    else $error("pointer read low bits not zero");
  cover property (mem_req_valid && mem_req_ready);
  cover property (snd_valid && !snd_ready ##1 snd_valid && snd_ready);
  cover property (ar_go && s_axi_araddr == SDDMA_OFF_CTRL);
endmodule
bind sddma_top sddma_props sddma_props_inst (.*);

/* File: verif/sddma_mem_model.sv */
// Memory model answering quad-word fetches, prompt or slow
`timescale 1ns/1ns
module sddma_mem_model (
  // Clock, reset and pace
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  // Request and answer
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire logic [28:0] mem_req_addr,
  output logic mem_rsp_valid,
  output logic [127:0] mem_rsp_data
);
  logic busy;
  logic [28:0] addr_q;
  int wait_n;
  always @(posedge aclk) begin
    mem_rsp_valid <= 1'b0;
    mem_rsp_data <= ~mem_rsp_data;
    mem_req_ready <= !slow || $urandom_range(1);
    if (!aresetn) begin
      busy <= 1'b0;
      mem_rsp_data <= 128'h0;
    end else if (busy) begin
      if (wait_n == 0) begin
        busy <= 1'b0;
        mem_rsp_valid <= 1'b1;
        mem_rsp_data <= {4{3'h5, addr_q}};
      end
      wait_n <= wait_n - 1;
    end else if (mem_req_valid && mem_req_ready) begin
      busy <= 1'b1;
      addr_q <= mem_req_addr;
      wait_n <= slow ? 3 : 0;
    end
  end
endmodule

/* File: verif/tb_sound_dma_double_buffer.sv */
// Testbench: registers, double-buffered fetch and single transfer
`timescale 1ns/1ns
module tb_sound_dma_double_buffer;
  import sddma_pkg::*;
  logic aclk, aresetn, slow, stall, snd_ready, snd_valid, snd_irq, snd_last;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic mem_req_valid, mem_req_ready, mem_rsp_valid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [28:0] mem_req_addr;
  logic [127:0] mem_rsp_data, snd_data;
  logic [28:0] expq[$];
  int failures, n_checks;

  sddma_top sddma_top_inst (.*);
  sddma_mem_model sddma_mem_model_inst (.*);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic stop_test;
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic hang(input bit t);
    if (t) begin
      failures++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    hang(n >= 200);
  endtask

  task automatic rd_reg(input logic [11:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    hang(n >= 200);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    rd_reg(a);
    chk("register", e & m, rd & m);
    chk("rresp", SDDMA_RESP_OKAY, rs);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (expq.size() > 0 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    repeat (60) @(posedge aclk);
    chk("snd_valid", 1'b0, snd_valid);
    hang(n >= 2000);
  endtask

  // Sound stream against the expected fetch order
  always @(posedge aclk) begin
    snd_ready <= !stall || $urandom_range(3) == 0;
    if (aresetn && snd_valid && snd_ready) begin
      chk("snd_data", expq.size() > 0 ? {4{3'h5, expq[0]}} : 128'h0, snd_data);
      if (expq.size() > 0) void'(expq.pop_front());
    end
  end

  initial begin
    void'($urandom(32'hAA46));
    failures = 0;
    n_checks = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {slow, stall} = 2'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(SDDMA_OFF_CTRL, 32'h10, 32'hFF);
    rchk(SDDMA_OFF_STATE, 32'h6, 32'h7);
    wr(SDDMA_OFF_STATE, 32'h0);
    rchk(SDDMA_OFF_STATE, 32'h6, 32'h7);
    wr(SDDMA_OFF_CTRL, 32'hDF);
    rchk(SDDMA_OFF_CTRL, 32'h10, 32'hFF);
    wr(12'h1A0, 32'h1);
    chk("bresp", SDDMA_RESP_SLVERR, rs);
    rd_reg(12'h17C);
    chk("rresp", SDDMA_RESP_SLVERR, rs);
    for (int i = 0; i < 2; i++) begin
      v = $urandom();
      wr(SDDMA_OFF_CUR_A + 12'(i * 8), v);
      rchk(SDDMA_OFF_CUR_A + 12'(i * 8), v, 32'h1FFF_FFF0);
      wr(SDDMA_OFF_END_A + 12'(i * 8), v);
      rchk(SDDMA_OFF_END_A + 12'(i * 8), v & 32'hC000_0FF0, 32'hC000_0FFF);
    end
    chk("snd_irq", 1'b0, snd_irq);
    rchk(SDDMA_OFF_STATE, 32'h0, 32'h7);
    wr(SDDMA_OFF_CTRL, 32'h80);
    chk("snd_irq", 1'b1, snd_irq);
    rchk(SDDMA_OFF_STATE, 32'h6, 32'h7);
    rchk(SDDMA_OFF_CTRL, 32'h10, 32'hFF);
    slow <= 1'b1;
    stall <= 1'b1;
    wr(SDDMA_OFF_CUR_A, 32'h0123_4100);
    wr(SDDMA_OFF_END_A, 32'h0000_0120);
    wr(SDDMA_OFF_CUR_B, 32'h0234_5300);
    wr(SDDMA_OFF_END_B, 32'h8000_0310);
    for (int i = 0; i < 3; i++) expq.push_back(29'h0123_4100 + 29'(i * 16));
    for (int i = 0; i < 2; i++) expq.push_back(29'h0234_5300 + 29'(i * 16));
    wr(SDDMA_OFF_CTRL, 32'h20);
    drain();
    rchk(SDDMA_OFF_CUR_A, 32'h0123_4130, 32'h1FFF_FFFF);
    rchk(SDDMA_OFF_CUR_B, 32'h0234_5320, 32'h1FFF_FFFF);
    rchk(SDDMA_OFF_STATE, 32'h3, 32'h7);
    chk("snd_irq", 1'b1, snd_irq);
    chk("snd_last", 1'b0, snd_last);
    rchk(SDDMA_OFF_CTRL, 32'h30, 32'hFF);
    wr(SDDMA_OFF_CTRL, 32'h0);
    for (int i = 0; i < 2; i++) begin
      wr(SDDMA_OFF_CUR_A + 12'(i * 8), 32'h0777_7400);
      wr(SDDMA_OFF_END_A + 12'(i * 8), 32'h4000_0400);
    end
    expq.push_back(29'h0777_7400);
    slow <= 1'b0;
    stall <= 1'b0;
    wr(SDDMA_OFF_CTRL, 32'h20);
    drain();
    chk("snd_last", 1'b1, snd_last);
    chk("snd_irq", 1'b0, snd_irq);
    rchk(SDDMA_OFF_STATE, 32'h1, 32'h7);
    stop_test();
  end
endmodule
